// ### rtl/sbl_consts.vh
// Constants for the secure boot loader of one processor tile.
// What this block does and expects of its controller
// (R01) Active-low reset; wait PLL lock before booting
// (R02) Pins weakly pulled down while reset held
// (R03) Controller holds reset 1 ms after supply good
// (R04) Internal reset sequence 15 to 150 us first
// (R05) Security bit 5 selects OTP boot, else flash
// (R06) Image: count, count words, checksum, LSB first
// (R07) Sentinel checksum value skips verification
// (R08) Program loads at RAM zero, runs there
// (R09) Reflected CRC-32, all-ones start, inverted result
// (R10) Bad checksum without sentinel blocks execution
// (R11) OTP is four sectors of 512 words
// (R12) Security register loaded from OTP at power-up
// (R13) Remaining OTP copied to SRAM, run first
// (R14) OTP programmed via address, data, control ports
// (R15) Bit 0 blocks test port; bit 1 blocks links
// (R16) Bit 7 enables OTP redundant rows
// (R17) Bits 8 to 11 lock sectors 0 to 3
// (R18) Bit 12 locks all programming and security
// (R19) Bit 13 blocks test-port OTP reads and writes
// (R20) Bits 21:15 general; 31:22 user code extension
// (R21) Test port: 4-bit instruction, 32-bit data, chained
// (R22) Controller holds test reset low 100 ns
// (R23) Identification word has fixed one at bit 0
// (R24) User code word holds security bits 31:22
`ifndef SBL_CONSTS_VH
`define SBL_CONSTS_VH
`define SBL_CLK_PERIOD_NS 25
`define SBL_INIT_MIN_NS 15000
`define SBL_INIT_CYCLES \
  ((`SBL_INIT_MIN_NS + `SBL_CLK_PERIOD_NS - 1) / `SBL_CLK_PERIOD_NS)
`define SBL_OTP_AW 11
`define SBL_OTP_ROWS 2048
`define SBL_SEC_ROW 11'h7ff
`define SBL_CRC_POLY 32'hedb88320
`define SBL_CRC_INIT 32'hffffffff
`define SBL_CRC_SKIP 32'h0d15ab1e
`define SBL_PORT_OTP_ADDR 24'h100200
`define SBL_PORT_OTP_DATA 24'h200100
`define SBL_PORT_OTP_CTRL 24'h100300
`define SBL_CTRL_WR_ROW 0
`define SBL_CTRL_WR_SEC 1
`define SBL_SEC_JTAG_OFF 0
`define SBL_SEC_LINK_OFF 1
`define SBL_SEC_OTP_BOOT 5
`define SBL_SEC_REDUND 7
`define SBL_SEC_LOCK0 8
`define SBL_SEC_MASTER 12
`define SBL_SEC_JTAG_OTP 13
`define SBL_IR_ID_WORD 4'h1
`define SBL_IR_USER_WORD 4'h2
`define SBL_IR_CHIP 4'h3
`define SBL_SEC_RESET 32'h00000000
`endif

// ### rtl/sbl_otp_mem.v
// One-time programmable word array with a registered read port.
`timescale 1ns/1ps
`include "sbl_consts.vh"
module sbl_otp_mem (
  input wire clk_i, // Tile clock.
  input wire we_i, // Program one row.
  input wire [`SBL_OTP_AW-1:0] addr_i, // Row address.
  input wire [31:0] wdata_i, // Row data to program.
  output reg [31:0] rdata_o // Registered read data.
);
  reg [31:0] mem [0:`SBL_OTP_ROWS-1];

  // Programming only sets bits, as fuses do; reads return a cycle later.
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= mem[addr_i] | wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// ### rtl/sbl_loader.v
// Boot sequencer, image parser, security register and test-port words.
`timescale 1ns/1ps
`include "sbl_consts.vh"
module sbl_loader #(
  parameter [3:0] ID_VERSION = 4'h0, // Arbitrary value.
  parameter [15:0] ID_PART = 16'h0000, // Arbitrary value.
  parameter [10:0] ID_MAKER = 11'h000, // Arbitrary value.
  parameter [5:0] SILICON_REV = 6'h00 // Arbitrary value.
) (
  input wire clk_i, // Tile clock, 40 MHz.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire pll_lock_i, // PLL lock from the analog block.
  input wire flash_valid_i, // Flash byte valid.
  input wire [7:0] flash_byte_i, // Flash byte data.
  output reg flash_ready_o, // Loader accepts a flash byte.
  input wire prog_stb_i, // Programming request strobe.
  input wire [15:0] prog_addr_i, // OTP address port value.
  input wire [31:0] prog_data_i, // OTP data port value.
  input wire [15:0] prog_ctrl_i, // OTP control port value.
  input wire prog_from_tap_i, // Request comes from the test port.
  output reg prog_done_o, // Programming request accepted.
  output reg prog_err_o, // Programming request refused.
  input wire tap_capture_i, // Capture data register strobe.
  input wire [3:0] tap_ir_i, // Test-port instruction.
  output reg [31:0] tap_dr_o, // Captured 32-bit data register.
  output reg chip_tap_sel_o, // Chain to the internal chip port.
  output reg gpio_pulldown_o, // Weak pull-downs on general pins.
  output reg tile_hold_o, // Holds the processor in reset.
  output reg ram_we_o, // RAM write pulse.
  output reg [15:0] ram_addr_o, // RAM word address.
  output reg [31:0] ram_wdata_o, // RAM write data.
  output reg run_o, // Processor starts execution.
  output reg [15:0] exec_addr_o, // Execution start word address.
  output reg crc_err_o, // Image checksum mismatch.
  output reg [31:0] sec_cfg_o, // Security register contents.
  output reg jtag_block_o, // Test port cut from tile state.
  output reg link_block_o, // Other tiles cut from processor state.
  output reg jtag_otp_block_o, // Test port cut from the OTP.
  output reg redund_en_o // Redundant OTP rows enabled.
);
  localparam [6:0] S_WAIT = 7'h01;
  localparam [6:0] S_INIT = 7'h02;
  localparam [6:0] S_SECR = 7'h04;
  localparam [6:0] S_SECL = 7'h08;
  localparam [6:0] S_LOAD = 7'h10;
  localparam [6:0] S_RUN = 7'h20;
  localparam [6:0] S_FAIL = 7'h40;
  localparam [2:0] P_COUNT = 3'h1;
  localparam [2:0] P_PROG = 3'h2;
  localparam [2:0] P_CRC = 3'h4;
  localparam integer INIT_CYC = `SBL_INIT_CYCLES;
  localparam [15:0] INIT_CNT = INIT_CYC[15:0];

  // Reflected CRC-32 over one word taken least significant bit first.
  function [31:0] sbl_crc_word;
    input [31:0] crc;
    input [31:0] data;
    integer i;
    reg [31:0] c;
    begin
      c = crc;
      for (i = 0; i < 32; i = i + 1) begin
        if (c[0] ^ data[i]) begin
          c = (c >> 1) ^ `SBL_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      sbl_crc_word = c;
    end
  endfunction

  reg [6:0] state_reg;
  reg [6:0] state_next;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [31:0] remain_reg;
  reg [31:0] remain_next;
  reg [31:0] crc_reg;
  reg [31:0] crc_next;
  reg [31:0] asm_reg;
  reg [31:0] asm_next;
  reg [1:0] byte_reg;
  reg [1:0] byte_next;
  reg [10:0] otp_ptr_reg;
  reg [10:0] otp_ptr_next;
  reg otp_pend_reg;
  reg otp_pend_next;
  reg [15:0] wptr_reg;
  reg [15:0] wptr_next;
  reg [2:0] lock_sync_reg;
  reg lock_reg;
  reg [31:0] sec_next;
  reg word_v;
  reg [31:0] word_d;
  reg mem_we;
  reg [10:0] mem_addr;
  reg [31:0] mem_wdata;
  reg prog_ok;
  reg [1:0] sector;
  wire [31:0] otp_rdata;

  sbl_otp_mem u_otp (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(otp_rdata)
  );

  // Lock from the PLL passes three flops; it counts once two agree.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_sync_reg <= 3'h0;
      lock_reg <= 1'b0;
    end else begin
      lock_sync_reg <= {lock_sync_reg[1:0], pll_lock_i};
      if (lock_sync_reg[1] == lock_sync_reg[2]) begin
        lock_reg <= lock_sync_reg[2];
      end
    end
  end

  // Programming is gated by the sector, master and test-port locks.
  always @* begin
    sector = prog_addr_i[10:9];
    prog_ok = !sec_cfg_o[`SBL_SEC_MASTER]; // R18
    if (prog_from_tap_i && sec_cfg_o[`SBL_SEC_JTAG_OTP]) begin
      prog_ok = 1'b0; // R19
    end
    if (prog_ctrl_i[`SBL_CTRL_WR_ROW] &&
        sec_cfg_o[`SBL_SEC_LOCK0 + sector]) begin
      prog_ok = 1'b0; // R17
    end
    if (state_reg != S_RUN && state_reg != S_FAIL) begin
      prog_ok = 1'b0;
    end
  end

  // One OTP port: the loader reads it, programming writes it afterwards.
  always @* begin
    mem_we = 1'b0;
    mem_addr = otp_ptr_reg;
    mem_wdata = prog_data_i;
    if (state_reg == S_SECR || state_reg == S_SECL) begin
      mem_addr = `SBL_SEC_ROW; // R12
    end
    if (prog_stb_i && prog_ok) begin // R14
      if (prog_ctrl_i[`SBL_CTRL_WR_SEC]) begin
        mem_we = 1'b1;
        mem_addr = `SBL_SEC_ROW;
      end else if (prog_ctrl_i[`SBL_CTRL_WR_ROW]) begin
        mem_we = 1'b1;
        mem_addr = prog_addr_i[10:0]; // R11
      end
    end
  end

  // Word source: OTP rows when secure boot is set, else flash bytes.
  always @* begin
    word_v = 1'b0;
    word_d = otp_rdata;
    asm_next = asm_reg;
    byte_next = byte_reg;
    otp_ptr_next = otp_ptr_reg;
    otp_pend_next = 1'b0;
    if (state_reg == S_LOAD) begin
      if (sec_cfg_o[`SBL_SEC_OTP_BOOT]) begin // R05
        word_v = otp_pend_reg; // R13
        otp_pend_next = !otp_pend_reg;
        if (otp_pend_reg) begin
          otp_ptr_next = otp_ptr_reg + 11'h001;
        end
      end else if (flash_valid_i && flash_ready_o) begin
        asm_next = {flash_byte_i, asm_reg[31:8]}; // R06
        byte_next = byte_reg + 2'h1;
        if (byte_reg == 2'h3) begin
          word_v = 1'b1;
          word_d = {flash_byte_i, asm_reg[31:8]};
        end
      end
    end
  end

  // Sequencer and image parser.
  always @* begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    remain_next = remain_reg;
    crc_next = crc_reg;
    wptr_next = wptr_reg;
    sec_next = sec_cfg_o;
    if (prog_stb_i && prog_ok && prog_ctrl_i[`SBL_CTRL_WR_SEC]) begin
      sec_next = sec_cfg_o | prog_data_i;
    end
    case (state_reg)
      S_WAIT: begin
        cnt_next = 16'h0000;
        if (lock_reg) begin
          state_next = S_INIT; // R01
        end
      end
      S_INIT: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == INIT_CNT - 16'h0001) begin
          state_next = S_SECR; // R04
        end
      end
      S_SECR: begin
        state_next = S_SECL;
      end
      S_SECL: begin
        sec_next = otp_rdata; // R12
        state_next = S_LOAD;
        phase_next = P_COUNT;
        crc_next = `SBL_CRC_INIT; // R09
        wptr_next = 16'h0000; // R08
      end
      S_LOAD: begin
        if (word_v) begin
          case (phase_reg)
            P_COUNT: begin
              remain_next = word_d; // R06
              crc_next = sbl_crc_word(crc_reg, word_d); // R09
              phase_next = (word_d == 32'h0) ? P_CRC : P_PROG;
            end
            P_PROG: begin
              crc_next = sbl_crc_word(crc_reg, word_d); // R09
              remain_next = remain_reg - 32'h1;
              wptr_next = wptr_reg + 16'h0001;
              if (remain_reg == 32'h1) begin
                phase_next = P_CRC;
              end
            end
            P_CRC: begin
              if (word_d == `SBL_CRC_SKIP) begin
                state_next = S_RUN; // R07
              end else if (word_d == ~crc_reg) begin
                state_next = S_RUN; // R09
              end else begin
                state_next = S_FAIL; // R10
              end
            end
            default: begin
              phase_next = P_COUNT;
            end
          endcase
        end
      end
      S_RUN: begin
        state_next = S_RUN;
      end
      S_FAIL: begin
        state_next = S_FAIL; // R10
      end
      default: begin
        state_next = S_WAIT;
      end
    endcase
  end

  // State and datapath registers.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_WAIT;
      phase_reg <= P_COUNT;
      cnt_reg <= 16'h0000;
      remain_reg <= 32'h0;
      crc_reg <= `SBL_CRC_INIT;
      asm_reg <= 32'h0;
      byte_reg <= 2'h0;
      otp_ptr_reg <= 11'h000;
      otp_pend_reg <= 1'b0;
      wptr_reg <= 16'h0000;
      sec_cfg_o <= `SBL_SEC_RESET;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      remain_reg <= remain_next;
      crc_reg <= crc_next;
      asm_reg <= asm_next;
      byte_reg <= byte_next;
      otp_ptr_reg <= otp_ptr_next;
      otp_pend_reg <= otp_pend_next;
      wptr_reg <= wptr_next;
      sec_cfg_o <= sec_next;
    end
  end

  // Boot outputs, RAM writes and reset-time pin behaviour.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      gpio_pulldown_o <= 1'b1; // R02
      tile_hold_o <= 1'b1; // R01
      flash_ready_o <= 1'b0;
      ram_we_o <= 1'b0;
      ram_addr_o <= 16'h0000;
      ram_wdata_o <= 32'h0;
      run_o <= 1'b0;
      exec_addr_o <= 16'h0000;
      crc_err_o <= 1'b0;
    end else begin
      gpio_pulldown_o <= 1'b0;
      tile_hold_o <= (state_next != S_RUN); // R10
      flash_ready_o <= (state_next == S_LOAD) &&
        !sec_next[`SBL_SEC_OTP_BOOT];
      ram_we_o <= word_v && (phase_reg == P_PROG);
      ram_addr_o <= wptr_reg; // R08
      ram_wdata_o <= word_d;
      run_o <= (state_next == S_RUN); // R10
      exec_addr_o <= 16'h0000; // R08
      crc_err_o <= (state_next == S_FAIL); // R10
    end
  end

  // Security bits drive the access blocks; programming answers.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      jtag_block_o <= 1'b0;
      link_block_o <= 1'b0;
      jtag_otp_block_o <= 1'b0;
      redund_en_o <= 1'b0;
      prog_done_o <= 1'b0;
      prog_err_o <= 1'b0;
    end else begin
      jtag_block_o <= sec_next[`SBL_SEC_JTAG_OFF]; // R15
      link_block_o <= sec_next[`SBL_SEC_LINK_OFF]; // R15
      jtag_otp_block_o <= sec_next[`SBL_SEC_JTAG_OTP]; // R19
      redund_en_o <= sec_next[`SBL_SEC_REDUND]; // R16
      prog_done_o <= prog_stb_i && prog_ok;
      prog_err_o <= prog_stb_i && !prog_ok; // R17
    end
  end

  // Test-port data register capture and chip-port chaining.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      tap_dr_o <= 32'h0;
      chip_tap_sel_o <= 1'b0;
    end else begin
      chip_tap_sel_o <= (tap_ir_i == `SBL_IR_CHIP) &&
        !sec_cfg_o[`SBL_SEC_JTAG_OFF]; // R21
      if (tap_capture_i) begin
        case (tap_ir_i)
          `SBL_IR_ID_WORD: begin
            tap_dr_o <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // R23
          end
          `SBL_IR_USER_WORD: begin
            tap_dr_o <= {sec_cfg_o[31:22], 4'h0, SILICON_REV,
              12'h000}; // R20 R24
          end
          default: begin
            tap_dr_o <= 32'h0; // R21
          end
        endcase
      end
    end
  end
endmodule

// ### test/sbl_loader_sva.sv
// Concurrent checks on the secure boot loader ports.
`timescale 1ns/1ps
module sbl_loader_sva (
  input wire clk_i, // Clock.
  input wire rst_n_i, // Reset.
  input wire pll_lock_i, // Lock.
  input wire flash_ready_o, // Load phase.
  input wire gpio_pulldown_o, // Pulls.
  input wire tile_hold_o, // Hold.
  input wire run_o, // Run.
  input wire crc_err_o, // Bad image.
  input wire [15:0] exec_addr_o, // Start.
  input wire [31:0] sec_cfg_o, // Security.
  input wire jtag_block_o, // Scan cut.
  input wire link_block_o, // Link cut.
  input wire prog_stb_i, // Request.
  input wire [15:0] prog_addr_i, // Address.
  input wire [15:0] prog_ctrl_i, // Control.
  input wire prog_from_tap_i, // From scan.
  input wire prog_err_o, // Refused.
  input wire tap_capture_i, // Capture.
  input wire [3:0] tap_ir_i, // Instruction.
  input wire [31:0] tap_dr_o // Data.
);
  reg [12:0] since_rel_reg;
  // Cycles since reset release, saturating, to judge the boot delay.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      since_rel_reg <= 13'h0000;
    end else if (since_rel_reg != 13'h1fff) begin
      since_rel_reg <= since_rel_reg + 13'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_held;
    !rst_n_i [*2];
  endsequence
  sequence s_load_start;
    !flash_ready_o ##1 flash_ready_o;
  endsequence
  property p_reset_pins;
    disable iff (1'b0) s_held |-> gpio_pulldown_o && tile_hold_o;
  endproperty
  a_reset_pull_down: assert property (p_reset_pins)
    else $error("pins not pulled down in reset");
  a_boot_delay: assert property (s_load_start |->
    since_rel_reg >= 600 && since_rel_reg <= 6000) else $error("boot delay");
  a_boot_lock: assert property (s_load_start |-> $past(pll_lock_i, 8))
    else $error("boot before lock");
  a_run_clean: assert property (run_o |-> !crc_err_o &&
    !tile_hold_o && exec_addr_o == 16'h0000) else $error("bad run");
  a_scan_block: assert property ($past(rst_n_i) && $stable(sec_cfg_o)
    |-> jtag_block_o == sec_cfg_o[0] && link_block_o == sec_cfg_o[1])
    else $error("block bits wrong");
  a_sector_lock: assert property (prog_stb_i &&
    prog_ctrl_i[1:0] == 2'b01 && sec_cfg_o[8 + prog_addr_i[10:9]]
    |=> prog_err_o) else $error("locked sector written");
  a_master_lock: assert property (prog_stb_i && sec_cfg_o[12]
    |=> prog_err_o) else $error("master lock ignored");
  a_tap_otp_guard: assert property (prog_stb_i && prog_from_tap_i
    && sec_cfg_o[13] |=> prog_err_o) else $error("scan write allowed");
  a_id_word_lsb: assert property (tap_capture_i && tap_ir_i == 4'h1
    |=> tap_dr_o[0]) else $error("id bit0 low");
endmodule
bind sbl_loader sbl_loader_sva sbl_loader_sva_inst (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .pll_lock_i(pll_lock_i), .flash_ready_o(flash_ready_o),
  .gpio_pulldown_o(gpio_pulldown_o), .tile_hold_o(tile_hold_o),
  .run_o(run_o), .crc_err_o(crc_err_o), .exec_addr_o(exec_addr_o),
  .sec_cfg_o(sec_cfg_o), .jtag_block_o(jtag_block_o),
  .link_block_o(link_block_o), .prog_stb_i(prog_stb_i),
  .prog_addr_i(prog_addr_i), .prog_ctrl_i(prog_ctrl_i),
  .prog_from_tap_i(prog_from_tap_i), .prog_err_o(prog_err_o),
  .tap_capture_i(tap_capture_i), .tap_ir_i(tap_ir_i), .tap_dr_o(tap_dr_o));

// ### test/sbl_flash_model.sv
// Behavioural serial flash that streams a boot image byte by byte.
`timescale 1ns/1ps
module sbl_flash_model (
  input wire clk_i, // Clock.
  input wire rst_n_i, // Reset, active low.
  input wire ready_i, // Loader takes a byte.
  output reg valid_o, // Byte on offer.
  output reg [7:0] byte_o // Offered byte.
);
  reg [7:0] mem [0:31];
  integer len = 0;
  integer pos_reg = 0;
  reg slow = 1'b0;
  initial valid_o = 1'b0;
  initial byte_o = 8'h00;
  // Bytes go out in order and are held until taken; slow mode idles
  // a cycle between bytes, and a released line shows the inverse.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      pos_reg <= 0;
    end else if (valid_o && ready_i) begin
      pos_reg <= pos_reg + 1;
      valid_o <= !slow && pos_reg + 1 < len;
      byte_o <= (!slow && pos_reg + 1 < len) ? mem[pos_reg + 1] :
        ~byte_o;
    end else if (!valid_o && pos_reg < len) begin
      valid_o <= 1'b1;
      byte_o <= mem[pos_reg];
    end
  end
endmodule

// ### test/tb.sv
// Self-checking bench for the secure boot loader.
`timescale 1ns/1ps
module tb;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg pll_lock_i = 1'b0;
  reg prog_stb_i = 1'b0;
  reg prog_from_tap_i = 1'b0;
  reg tap_capture_i = 1'b0;
  reg [3:0] tap_ir_i = 4'h0;
  reg [15:0] prog_addr_i = 16'h0000;
  reg [15:0] prog_ctrl_i = 16'h0000;
  reg [31:0] prog_data_i = 32'h00000000;
  wire fl_v, fl_r, p_done, p_err, chain, pulldn, hold, ram_we, run;
  wire crc_err, jblk, lblk, joblk, redund;
  wire [7:0] fl_b;
  wire [15:0] ram_a, exec_a;
  wire [31:0] tap_dr, ram_d, sec;
  reg [31:0] ram [0:15];
  reg [31:0] img [0:7];
  integer n_ram = 0;
  integer n_fail = 0;
  integer cmp_count = 0;
  // Identity values below are arbitrary.
  sbl_loader #(.ID_VERSION(4'h3), .ID_PART(16'h0a5c), .ID_MAKER(11'h2b7),
    .SILICON_REV(6'h15)) sbl_loader_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .pll_lock_i(pll_lock_i), .flash_valid_i(fl_v), .flash_byte_i(fl_b),
    .flash_ready_o(fl_r), .prog_stb_i(prog_stb_i), .prog_addr_i(prog_addr_i),
    .prog_data_i(prog_data_i), .prog_ctrl_i(prog_ctrl_i),
    .prog_from_tap_i(prog_from_tap_i), .prog_done_o(p_done),
    .prog_err_o(p_err), .tap_capture_i(tap_capture_i), .tap_ir_i(tap_ir_i),
    .tap_dr_o(tap_dr), .chip_tap_sel_o(chain), .gpio_pulldown_o(pulldn),
    .tile_hold_o(hold), .ram_we_o(ram_we), .ram_addr_o(ram_a),
    .ram_wdata_o(ram_d), .run_o(run), .exec_addr_o(exec_a),
    .crc_err_o(crc_err), .sec_cfg_o(sec), .jtag_block_o(jblk),
    .link_block_o(lblk), .jtag_otp_block_o(joblk), .redund_en_o(redund));
  sbl_flash_model fl (.clk_i(clk_i), .rst_n_i(rst_n_i), .ready_i(fl_r),
    .valid_o(fl_v), .byte_o(fl_b));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Record every RAM write the loader makes.
  always @(posedge clk_i) begin
    if (ram_we === 1'b1) begin
      ram[ram_a[3:0]] <= ram_d;
      n_ram <= n_ram + 1;
    end
  end
  task final_report;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input ok, input [127:0] msg);
    begin
      cmp_count = cmp_count + 1;
      if (ok !== 1'b1) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t %0s", $time, msg);
      end
    end
  endtask
  function [31:0] crc8(input [31:0] c, input [7:0] b);
    integer k;
    begin
      crc8 = c ^ {24'h000000, b};
      for (k = 0; k < 8; k = k + 1)
        crc8 = crc8[0] ? (crc8 >> 1) ^ 32'hedb88320 : crc8 >> 1;
    end
  endfunction
  // Build an image, reset, boot and judge the outcome.
  task boot(input [31:0] n, input [1:0] mode, input otp);
    integer k;
    integer j;
    reg [31:0] w;
    reg [31:0] c;
    begin
      c = 32'hffffffff;
      for (k = 0; k < n + 2; k = k + 1) begin
        w = (k == 0) ? n : {4{k[7:0]}} ^ 32'h5a3c0f81;
        if (k == n + 1)
          w = (mode == 2'd2) ? 32'h0d15ab1e : ~c ^ {30'h0, mode};
        for (j = 0; j < 4; j = j + 1) begin
          if (k <= n)
            c = crc8(c, w[8*j +: 8]);
          fl.mem[4*k + j] = w[8*j +: 8];
        end
        img[k] = w;
        sbl_loader_inst.u_otp.mem[k] = w;
      end
      sbl_loader_inst.u_otp.mem[2047] = otp ? 32'h00000020 : 32'h00000000;
      fl.slow = (mode == 2'd0);
      fl.len = otp ? 0 : 4 * (n + 2);
      n_ram = 0;
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      pll_lock_i <= 1'b0;
      // Supply and test-port reset are taken as settled from time zero.
      repeat (16) @(posedge clk_i);
      #1 chk(pulldn === 1'b1 && hold === 1'b1, "reset pins");
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      pll_lock_i <= 1'b1;
      #1 chk(fl_r === 1'b0, "load before lock");
      chk(pulldn === 1'b0, "pulls after rst");
      prog(2'd1, 16'h0000, 32'h00000000, 1'b0, 1'b0);
      for (k = 0; k < 3000 && run !== 1'b1 && crc_err !== 1'b1; k = k + 1)
        @(posedge clk_i);
      if (k == 3000) begin
        chk(1'b0, "boot timeout");
        final_report;
      end
      #1;
      if (mode == 2'd1)
        chk(crc_err === 1'b1 && run === 1'b0 && hold === 1'b1,
          "bad ran");
      else
        chk(run === 1'b1 && hold === 1'b0 && exec_a === 16'h0,
          "no run");
      chk(n_ram === n, "ram count");
      for (k = 0; k < n; k = k + 1)
        chk(ram[k] === img[k + 1], "ram word");
    end
  endtask
  task prog(input [1:0] ctl, input [15:0] a, input [31:0] d, input tap,
    input ok);
    begin
      @(posedge clk_i);
      prog_ctrl_i <= {14'h0000, ctl};
      prog_addr_i <= a;
      prog_data_i <= d;
      prog_from_tap_i <= tap;
      prog_stb_i <= 1'b1;
      @(posedge clk_i);
      prog_stb_i <= 1'b0;
      #1 chk(p_done === ok && p_err === !ok, "prog answer");
    end
  endtask
  task tap(input [3:0] ir, input [31:0] dr, input sel);
    begin
      @(posedge clk_i);
      tap_ir_i <= ir;
      tap_capture_i <= 1'b1;
      @(posedge clk_i);
      tap_capture_i <= 1'b0;
      #1 chk(tap_dr === dr && chain === sel, "tap word");
    end
  endtask
  // Main sequence.
  initial begin
    boot(3, 2'd0, 1'b0);
    tap(4'h1, {4'h3, 16'h0a5c, 11'h2b7, 1'b1}, 1'b0);
    tap(4'h3, 32'h0, 1'b1);
    prog(2'd1, 16'h0200, 32'h00000011, 1'b0, 1'b1);
    prog(2'd2, 16'h0000, 32'hffc28283, 1'b0, 1'b1);
    chk(sec === 32'hffc28283, "sec bits");
    chk({jblk, lblk, redund, joblk} === 4'b1110, "block bits");
    tap(4'h2, {10'h3ff, 4'h0, 6'h15, 12'h000}, 1'b0);
    tap(4'h3, 32'h0, 1'b0);
    prog(2'd1, 16'h0200, 32'h00000022, 1'b0, 1'b0);
    prog(2'd1, 16'h0600, 32'h00000044, 1'b0, 1'b1);
    prog(2'd2, 16'h0000, 32'h00002000, 1'b0, 1'b1);
    prog(2'd1, 16'h0000, 32'h00000088, 1'b1, 1'b0);
    prog(2'd1, 16'h0000, 32'h00000088, 1'b0, 1'b1);
    prog(2'd2, 16'h0000, 32'h00001000, 1'b0, 1'b1);
    prog(2'd1, 16'h0400, 32'h00000001, 1'b0, 1'b0);
    prog(2'd2, 16'h0000, 32'h00000100, 1'b0, 1'b0);
    boot(1, 2'd1, 1'b0);
    boot(0, 2'd2, 1'b0);
    boot(2, 2'd0, 1'b1);
    chk(sec === 32'h00000020, "sec load");
    final_report;
  end
endmodule
